// file: src/lfc_codec.sv
// module: coefficient register file over AXI4-Lite and decoder to fixed-point gains
`timescale 1ns/100ps
`default_nettype none
module lfc_codec #(
	parameter int COEF_W = 96,
	parameter int COEF_FRAC = 64
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [lfc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [lfc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic signed [COEF_W-1:0] alpha_gain,
	output logic signed [COEF_W-1:0] beta_gain,
	output logic signed [COEF_W-1:0] gamma_gain,
	output logic signed [COEF_W-1:0] delta_gain
);
	import lfc_pkg::*;

	// ****************************************
	// parameter check
	// ****************************************
	generate
		if (COEF_FRAC < 48 || COEF_FRAC > 200 || COEF_W < COEF_FRAC + 32)
		begin : g_bad
			$error("lfc_codec: COEF_W or COEF_FRAC out of range");
		end
	endgenerate

	// ****************************************
	// helpers
	// ****************************************
	// mantissa shifted by a signed power of two into the fixed-point format
	function automatic logic [COEF_W-1:0] scale(input logic [31:0] mant,
		input logic signed [8:0] e);
		logic [COEF_W-1:0] wide;
		logic [8:0] mag;
		wide = {{(COEF_W-32){1'b0}}, mant};
		mag = e[8] ? 9'(-e) : 9'(e);
		if (e[8])
			scale = wide >> mag;
		else
			scale = wide << mag;
	endfunction

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	// ****************************************
	// bus slave and register file
	// ****************************************
	logic aw_full, w_full;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] reg_alpha, reg_beta, reg_gamma, reg_delta;
	logic [31:0] exp_stat;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic next_aw_full, next_w_full;
	logic [ADDR_W-1:0] next_aw_addr;
	logic [31:0] next_w_data, next_rdata;
	logic [3:0] next_w_strb;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_alpha, next_beta, next_gamma, next_delta;
	logic wr_fire;

	always_comb
	begin
		next_awready = s_axi_awready;
		next_wready = s_axi_wready;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_arready = s_axi_arready;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		next_aw_full = aw_full;
		next_w_full = w_full;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_alpha = reg_alpha;
		next_beta = reg_beta;
		next_gamma = reg_gamma;
		next_delta = reg_delta;
		wr_fire = aw_full && w_full && !s_axi_bvalid;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_full = 1'b1;
			next_aw_addr = s_axi_awaddr;
			next_awready = 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_full = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
			next_wready = 1'b0;
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (wr_fire)
		begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_awready = 1'b1;
			next_wready = 1'b1;
			next_bvalid = 1'b1;
			next_bresp = RESP_OKAY;
			case ({aw_addr[ADDR_W-1:2], 2'b00})
				ADDR_ALPHA: next_alpha = merge(reg_alpha, w_data, w_strb);
				ADDR_BETA: next_beta = merge(reg_beta, w_data, w_strb);
				ADDR_GAMMA: next_gamma = merge(reg_gamma, w_data, w_strb);
				ADDR_DELTA: next_delta = merge(reg_delta, w_data, w_strb);
				ADDR_EXP: next_bresp = RESP_OKAY;
				default: next_bresp = RESP_SLVERR;
			endcase
		end
		if (s_axi_rvalid && s_axi_rready)
		begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = RESP_OKAY;
			case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
				ADDR_ALPHA: next_rdata = reg_alpha;
				ADDR_BETA: next_rdata = reg_beta;
				ADDR_GAMMA: next_rdata = reg_gamma;
				ADDR_DELTA: next_rdata = reg_delta;
				ADDR_EXP: next_rdata = exp_stat;
				default:
				begin
					next_rdata = 32'h0000_0000;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			reg_alpha <= RST_COEF;
			reg_beta <= RST_COEF;
			reg_gamma <= RST_COEF;
			reg_delta <= RST_COEF;
		end
		else
		begin
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			reg_alpha <= next_alpha;
			reg_beta <= next_beta;
			reg_gamma <= next_gamma;
			reg_delta <= next_delta;
		end
	end

	// ****************************************
	// coefficient decode
	// ****************************************
	logic signed [8:0] ea, eb, eg, ed, frac;
	logic [31:0] ma, mb, mg, md;
	logic [COEF_W-1:0] next_alpha_gain, next_beta_gain;
	logic [COEF_W-1:0] next_gamma_gain, next_delta_gain;
	logic [31:0] next_exp_stat;

	always_comb
	begin
		frac = 9'(COEF_FRAC);
		// unsigned field widths hold the largest shift and gain values
		ma = 32'(reg_alpha[ALPHA_MANT_W-1:0]);
		mb = 32'(reg_beta[BG_MANT_W-1:0]);
		mg = 32'(reg_gamma[BG_MANT_W-1:0]);
		md = 32'(reg_delta[DELTA_MANT_W-1:0]);
		ea = -ALPHA_BASE
			- 9'(reg_alpha[ALPHA_SHIFT_LSB +: ALPHA_SHIFT_W])
			+ 9'(reg_alpha[ALPHA_FG_LSB +: ALPHA_FG_W])
			+ 9'(reg_alpha[ALPHA_BG_LSB +: ALPHA_BG_W]);
		eb = -(BG_BASE + 9'(reg_beta[BG_EXP_LSB +: BG_EXP_W]));
		eg = -(BG_BASE + 9'(reg_gamma[BG_EXP_LSB +: BG_EXP_W]));
		ed = -(DELTA_BASE
			+ 9'(reg_delta[DELTA_EXP_LSB +: DELTA_EXP_W]));
		next_alpha_gain = scale(ma, 9'(frac + ea));
		next_beta_gain = ~scale(mb, 9'(frac + eb)) + 1'b1;
		next_gamma_gain = ~scale(mg, 9'(frac + eg)) + 1'b1;
		next_delta_gain = scale(md, 9'(frac + ed));
		next_exp_stat = {ed[7:0], eg[7:0], eb[7:0], ea[7:0]};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			alpha_gain <= '0;
			beta_gain <= '0;
			gamma_gain <= '0;
			delta_gain <= '0;
			exp_stat <= 32'h0000_0000;
		end
		else
		begin
			alpha_gain <= next_alpha_gain;
			beta_gain <= next_beta_gain;
			gamma_gain <= next_gamma_gain;
			delta_gain <= next_delta_gain;
			exp_stat <= next_exp_stat;
		end
	end
endmodule
`default_nettype wire

// file: src/lfc_pkg.sv
// package: register map, field layout and reset values of the coefficient codec
//
// Contract
// - beta and gamma are stored as positive magnitudes and are applied as negative coefficients inside the core.
// - effective alpha is the alpha mantissa times two to the minus 16, minus shift, plus front-end gain, plus back-end gain.
// - the beta magnitude is its mantissa times two to the minus (17 plus the beta exponent).
// - the gamma magnitude is its mantissa times two to the minus (17 plus the gamma exponent).
// - delta is its mantissa times two to the minus (15 plus the delta exponent).
package lfc_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] ADDR_ALPHA = 8'h00;
	localparam logic [7:0] ADDR_BETA = 8'h04;
	localparam logic [7:0] ADDR_GAMMA = 8'h08;
	localparam logic [7:0] ADDR_DELTA = 8'h0C;
	localparam logic [7:0] ADDR_EXP = 8'h10;
	localparam int ADDR_W = 8;
	// ****************************************
	// field layout
	// ****************************************
	localparam int ALPHA_MANT_W = 16;
	localparam int ALPHA_SHIFT_W = 6;
	localparam int ALPHA_FG_W = 3;
	localparam int ALPHA_BG_W = 4;
	localparam int ALPHA_SHIFT_LSB = 16;
	localparam int ALPHA_FG_LSB = 22;
	localparam int ALPHA_BG_LSB = 25;
	localparam int BG_MANT_W = 17;
	localparam int BG_EXP_W = 5;
	localparam int BG_EXP_LSB = 17;
	localparam int DELTA_MANT_W = 15;
	localparam int DELTA_EXP_W = 5;
	localparam int DELTA_EXP_LSB = 15;
	// ****************************************
	// fixed exponent offsets
	// ****************************************
	localparam logic signed [8:0] ALPHA_BASE = 9'sh010;
	localparam logic signed [8:0] BG_BASE = 9'sh011;
	localparam logic signed [8:0] DELTA_BASE = 9'sh00F;
	// ****************************************
	// reset values and responses
	// ****************************************
	localparam logic [31:0] RST_COEF = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: testbench/lfc_codec_bench.sv
// bench: register writes, read-back and gain checks for the codec
`timescale 1ns/100ps
`default_nettype none
module lfc_codec_bench;
	import lfc_pkg::*;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0;
	logic arv = 0, rready = 0;
	logic [3:0] wstrb = 4'hF;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic signed [95:0] ag, bg, gg, dg;
	int err_total = 0, samples_checked = 0;
	lfc_codec uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.alpha_gain(ag), .beta_gain(bg), .gamma_gain(gg), .delta_gain(dg));
	always #12.5 aclk = ~aclk;
	// ****************************************
	// tasks
	// ****************************************
	task automatic give_verdict();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [95:0] e,
		input logic [95:0] g);
		samples_checked++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awv <= 1;
		wv <= 1;
		bready <= 1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awv && awready)
				awv <= 0;
			if (wv && wready)
				wv <= 0;
		end
		while (bvalid !== 1'b1 && n < 40);
		bready <= 0;
		chk("bresp", 96'(er), 96'(bresp));
		if (bvalid !== 1'b1)
		begin
			err_total++;
			$display("MISMATCH bvalid exp 1 got %b", bvalid);
			give_verdict();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arv <= 1;
		rready <= 1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arv && arready)
				arv <= 0;
		end
		while (rvalid !== 1'b1 && n < 40);
		rready <= 0;
		chk("rdata", 96'(ed), 96'(rdata));
		chk("rresp", 96'(er), 96'(rresp));
		if (rvalid !== 1'b1)
		begin
			err_total++;
			$display("MISMATCH rvalid exp 1 got %b", rvalid);
			give_verdict();
		end
	endtask
	task automatic set4(input logic [31:0] a, b, g, d, x);
		wr(ADDR_ALPHA, a, RESP_OKAY);
		wr(ADDR_BETA, b, RESP_OKAY);
		wr(ADDR_GAMMA, g, RESP_OKAY);
		wr(ADDR_DELTA, d, RESP_OKAY);
		rd(ADDR_ALPHA, a, RESP_OKAY);
		rd(ADDR_BETA, b, RESP_OKAY);
		rd(ADDR_GAMMA, g, RESP_OKAY);
		rd(ADDR_DELTA, d, RESP_OKAY);
		rd(ADDR_EXP, x, RESP_OKAY);
	endtask
	task automatic gains(input logic [95:0] a, b, g, d);
		chk("alpha_gain", a, ag);
		chk("beta_gain", b, bg);
		chk("gamma_gain", g, gg);
		chk("delta_gain", d, dg);
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		rd(ADDR_ALPHA, RST_COEF, RESP_OKAY);
		gains(0, 0, 0, 0);
		set4(32'h0006D0A8,
			32'h001B250B, 32'h001B3ABB, 32'h0004420A, 32'hE9E2E2EA);
		gains(96'(53416) << 42,
			-(96'(75019) << 34), -(96'(80571) << 34),
			96'(16906) << 41);
		set4(32'h003FFFFF,
			32'h003FFFFF, 32'h00000001, 32'h000FFFFF, 32'hD2EFD0B1);
		gains(1,
			-(96'(131071) << 16), -(96'(1) << 47), 96'(32767) << 18);
		wr(ADDR_ALPHA, 32'h9FC00001, RESP_OKAY);
		wr(ADDR_EXP, 32'h0, RESP_OKAY);
		rd(ADDR_EXP, 32'hD2EFD006, RESP_OKAY);
		rd(ADDR_ALPHA, 32'h9FC00001, RESP_OKAY);
		chk("alpha_gain", 96'(1) << 70, ag);
		wstrb <= 4'h1;
		wr(ADDR_DELTA, 32'h12345600, RESP_OKAY);
		wstrb <= 4'hF;
		rd(ADDR_DELTA, 32'h000FFF00, RESP_OKAY);
		chk("delta_gain", 96'(32512) << 18, dg);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_DELTA, RST_COEF, RESP_OKAY);
		gains(0, 0, 0, 0);
		rd(ADDR_EXP, 32'hF1EFEFF0, RESP_OKAY);
		wr(8'h14, 32'h12345678, RESP_SLVERR);
		rd(8'h14, 32'h0, RESP_SLVERR);
		give_verdict();
	end
endmodule
`default_nettype wire

// file: testbench/lfc_codec_sva.sv
// checker: sign and update timing of the gain outputs
`timescale 1ns/100ps
`default_nettype none
module lfc_codec_sva #(
	parameter int COEF_W = 96
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic signed [COEF_W-1:0] alpha_gain,
	input wire logic signed [COEF_W-1:0] beta_gain,
	input wire logic signed [COEF_W-1:0] gamma_gain,
	input wire logic signed [COEF_W-1:0] delta_gain
);
	logic bv_q;
	logic upd_q;
	logic next_bv_q;
	logic next_upd_q;
	// ****************************************
	// write completion tracker
	// ****************************************
	always_comb
	begin
		next_bv_q = aresetn & s_axi_bvalid;
		next_upd_q = aresetn & s_axi_bvalid & ~bv_q;
	end
	always_ff @(posedge aclk)
	begin
		bv_q <= next_bv_q;
		upd_q <= next_upd_q;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_done;
		upd_q;
	endsequence
	// ****************************************
	// assertions
	// ****************************************
	a_beta_negative: assert property (beta_gain <= 0)
		else $error("beta gain positive");
	a_gamma_negative: assert property (gamma_gain <= 0)
		else $error("gamma gain positive");
	a_alpha_nonneg: assert property (alpha_gain >= 0)
		else $error("alpha gain negative");
	a_delta_nonneg: assert property (delta_gain >= 0)
		else $error("delta gain negative");
	a_alpha_on_write: assert property (
		$past(aresetn) && $changed(alpha_gain) |-> s_wr_done)
		else $error("alpha gain moved");
	a_beta_on_write: assert property (
		$past(aresetn) && $changed(beta_gain) |-> s_wr_done)
		else $error("beta gain moved");
	a_gamma_on_write: assert property (
		$past(aresetn) && $changed(gamma_gain) |-> s_wr_done)
		else $error("gamma gain moved");
	a_delta_on_write: assert property (
		$past(aresetn) && $changed(delta_gain) |-> s_wr_done)
		else $error("delta gain moved");
endmodule
bind lfc_codec lfc_codec_sva #(.COEF_W(COEF_W)) u_sva (.aclk(aclk),
	.aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .alpha_gain(alpha_gain),
	.beta_gain(beta_gain), .gamma_gain(gamma_gain), .delta_gain(delta_gain));
`default_nettype wire
